// file: src/tocu_map.svh
// Constants of the timer output compare block
`ifndef TOCU_MAP_SVH
`define TOCU_MAP_SVH
// ----------------------------------------
// Waveform mode codes
// ----------------------------------------
`define TOCU_WGM_NORMAL 4'h0
`define TOCU_WGM_CTC_CMPA 4'h4
`define TOCU_WGM_CTC_CAPT 4'hC
`define TOCU_WGM_FAST_8 4'h5
`define TOCU_WGM_FAST_9 4'h6
`define TOCU_WGM_FAST_10 4'h7
`define TOCU_WGM_FAST_CAPT 4'hE
`define TOCU_WGM_FAST_CMPA 4'hF
// ----------------------------------------
// Output mode field codes
// ----------------------------------------
`define TOCU_COM_OFF 2'h0
`define TOCU_COM_TOGGLE 2'h1
`define TOCU_COM_CLEAR 2'h2
`define TOCU_COM_SET 2'h3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TOCU_WAVE_RST 1'h0
`define TOCU_FLAG_RST 1'h0
`define TOCU_TEMP_RST 8'h00
`define TOCU_CMP_RST 16'h0000
`endif

// file: src/tocu_pkg.sv
// Types shared by the output compare block
package tocu_pkg;
    // Action applied to a wave output register
    typedef enum logic [1:0] {
        TOCU_ACT_NONE,
        TOCU_ACT_CLEAR,
        TOCU_ACT_SET,
        TOCU_ACT_TOGGLE
    } tocu_action_e;
endpackage : tocu_pkg

// file: src/tocu_cmp_reg.sv
// Compare value buffer and active register of one channel
`include "tocu_map.svh"
module tocu_cmp_reg
    import tocu_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic buffered,
    input wire logic wr_full,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic xfer,
    output logic [WIDTH-1:0] active_value,
    output logic [WIDTH-1:0] cpu_view
);
    logic [WIDTH-1:0] buffer_reg;
    logic [WIDTH-1:0] active_reg;

    // Buffer takes CPU words only while buffering is on
    always_ff @(posedge core_clk)
    begin
        if (srst)
            buffer_reg <= WIDTH'(`TOCU_CMP_RST);
        else if (wr_full && buffered)
            buffer_reg <= wr_data;
    end

    // Active value: direct write, or transfer at the turn point
    always_ff @(posedge core_clk)
    begin
        if (srst)
            active_reg <= WIDTH'(`TOCU_CMP_RST);
        else if (wr_full && !buffered)
            active_reg <= wr_data;
        else if (buffered && xfer)
            active_reg <= buffer_reg;
    end

    assign active_value = active_reg;
    // Read returns the register itself, never the temp byte
    assign cpu_view = buffered ? buffer_reg : active_reg;

    property p_direct_write;
        @(posedge core_clk) disable iff (srst)
        (wr_full && !buffered) |=> (active_reg == $past(wr_data));
    endproperty
    a_direct_write: assert property (p_direct_write)
        else $error("direct write did not reach active value");

    property p_hold_until_xfer;
        @(posedge core_clk) disable iff (srst)
        (buffered && !xfer && $past(buffered)) |=> $stable(active_reg);
    endproperty
    a_hold_until_xfer: assert property (p_hold_until_xfer)
        else $error("active value changed outside transfer point");
endmodule : tocu_cmp_reg

// file: src/tocu_wave_out.sv
// Wave output register and pin override of one channel
`include "tocu_map.svh"
module tocu_wave_out
    import tocu_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input tocu_action_e act,
    input wire logic [1:0] output_mode_field,
    input wire logic port_out_value,
    input wire logic pin_direction_bit,
    output logic wave_output,
    output logic pin_out,
    output logic pin_oe
);
    logic wave_reg;

    // Kept across mode changes; only reset or an action moves it
    always_ff @(posedge core_clk)
    begin
        if (srst)
            wave_reg <= `TOCU_WAVE_RST;
        else
            case (act)
                TOCU_ACT_CLEAR: wave_reg <= 1'b0;
                TOCU_ACT_SET: wave_reg <= 1'b1;
                TOCU_ACT_TOGGLE: wave_reg <= !wave_reg;
                default: wave_reg <= wave_reg;
            endcase
    end

    assign wave_output = wave_reg;
    // Any set mode bit hands the pin to the wave; direction stays with port
    assign pin_out = (output_mode_field != `TOCU_COM_OFF) ? wave_reg : port_out_value;
    assign pin_oe = pin_direction_bit;

    property p_pin_source;
        @(posedge core_clk) disable iff (srst)
        (output_mode_field != `TOCU_COM_OFF && pin_direction_bit) |-> (pin_oe && pin_out == wave_output);
    endproperty
    a_pin_source: assert property (p_pin_source)
        else $error("pin not driven from wave output");
endmodule : tocu_wave_out

// file: src/tocu_output_compare.sv
// Output compare section of a 16-bit timer, two channels
`include "tocu_map.svh"
module tocu_output_compare
    import tocu_pkg::*;
#(
    parameter int NCH = 2,
    parameter int WIDTH = 16
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic timer_tick,
    input wire logic [WIDTH-1:0] counter_value,
    input wire logic counter_at_top,
    input wire logic counter_at_bottom,
    input wire logic count_down,
    input wire logic pwm_mode,
    input wire logic [3:0] waveform_mode,
    input wire logic counter_write,
    input wire logic [7:0] cpu_wdata,
    input wire logic [NCH-1:0] compare_value_high_wr,
    input wire logic [NCH-1:0] compare_value_low_wr,
    input wire logic temp_load,
    input wire logic [7:0] temp_load_data,
    input wire logic [NCH-1:0] flag_clear_wr,
    input wire logic [NCH-1:0] irq_ack,
    input wire logic [NCH-1:0] compare_irq_enable,
    input wire logic [NCH-1:0] force_compare_strobe,
    input wire logic [NCH-1:0][1:0] output_mode_field,
    input wire logic [NCH-1:0] port_out_value,
    input wire logic [NCH-1:0] pin_direction_bit,
    output logic [7:0] temp_byte,
    output logic [NCH-1:0][WIDTH-1:0] compare_value,
    output logic [WIDTH-1:0] compare_top_a,
    output logic top_from_compare_a,
    output logic [NCH-1:0] compare_match,
    output logic [NCH-1:0] compare_flag,
    output logic [NCH-1:0] compare_irq,
    output logic [NCH-1:0] wave_output,
    output logic [NCH-1:0] pin_out,
    output logic [NCH-1:0] pin_oe
);

    // ----------------------------------------
    // Mode decoding
    // ----------------------------------------

    // Single-slope PWM modes
    function automatic logic is_fast(input logic [3:0] mode);
        is_fast = (mode == `TOCU_WGM_FAST_8) || (mode == `TOCU_WGM_FAST_9) ||
            (mode == `TOCU_WGM_FAST_10) || (mode == `TOCU_WGM_FAST_CAPT) ||
            (mode == `TOCU_WGM_FAST_CMPA);
    endfunction : is_fast

    // Action on a compare match, from output mode field and mode
    function automatic tocu_action_e match_action(
        input logic pwm,
        input logic fast,
        input logic down,
        input logic [1:0] com
    );
        match_action = TOCU_ACT_NONE;
        if (!pwm)
        begin
            // Set, clear or toggle in normal and CLEAR_ON_COMPARE_MODE modes
            case (com)
                `TOCU_COM_TOGGLE: match_action = TOCU_ACT_TOGGLE;
                `TOCU_COM_CLEAR: match_action = TOCU_ACT_CLEAR;
                `TOCU_COM_SET: match_action = TOCU_ACT_SET;
                default: match_action = TOCU_ACT_NONE;
            endcase
        end
        else
        begin
            // Non-inverted or inverted; dual slope flips on way down
            case (com)
                `TOCU_COM_CLEAR: match_action = (!fast && down) ? TOCU_ACT_SET : TOCU_ACT_CLEAR;
                `TOCU_COM_SET: match_action = (!fast && down) ? TOCU_ACT_CLEAR : TOCU_ACT_SET;
                default: match_action = TOCU_ACT_NONE;
            endcase
        end
    endfunction : match_action

    // Action at bottom in single-slope PWM
    function automatic tocu_action_e bottom_action(input logic [1:0] com);
        case (com)
            `TOCU_COM_CLEAR: bottom_action = TOCU_ACT_SET;
            `TOCU_COM_SET: bottom_action = TOCU_ACT_CLEAR;
            default: bottom_action = TOCU_ACT_NONE;
        endcase
    endfunction : bottom_action

    // ----------------------------------------
    // Shared decode
    // ----------------------------------------

    logic fast_mode;
    logic xfer_point;
    logic block_reg;
    logic blocked;
    logic [NCH-1:0][WIDTH-1:0] compare_top_w;

    assign fast_mode = pwm_mode && is_fast(waveform_mode);
    // Single slope reloads at bottom, dual slope at top
    assign xfer_point = timer_tick && (fast_mode ? counter_at_bottom : counter_at_top);

    // Channel A may define the period; the counter logic picks it up
    assign compare_top_a = compare_top_w[0];
    assign top_from_compare_a = (waveform_mode == `TOCU_WGM_CTC_CMPA) ||
        (waveform_mode == `TOCU_WGM_FAST_CMPA);

    // ----------------------------------------
    // Shared temp byte
    // ----------------------------------------

    logic [7:0] temp_reg;

    // One temp byte for every 16-bit register of the timer
    always_ff @(posedge core_clk)
    begin
        if (srst)
            temp_reg <= `TOCU_TEMP_RST;
        else if (|compare_value_high_wr)
            temp_reg <= cpu_wdata;
        else if (temp_load)
            temp_reg <= temp_load_data;
    end

    assign temp_byte = temp_reg;

    property p_temp_high;
        @(posedge core_clk) disable iff (srst)
        (|compare_value_high_wr) |=> (temp_byte == $past(cpu_wdata));
    endproperty
    a_temp_high: assert property (p_temp_high)
        else $error("high byte write missed the temp byte");

    // ----------------------------------------
    // Match blocking after a counter write
    // ----------------------------------------

    // Armed by a write, held while the timer clock stands still
    always_ff @(posedge core_clk)
    begin
        if (srst)
            block_reg <= 1'b0;
        else if (counter_write)
            block_reg <= 1'b1;
        else if (timer_tick)
            block_reg <= 1'b0;
    end

    // A write has priority over the count in its own cycle too
    assign blocked = block_reg || counter_write;

    // ----------------------------------------
    // Channels
    // ----------------------------------------

    logic [NCH-1:0] equal_w;
    logic [NCH-1:0] match_evt;
    logic [NCH-1:0] flag_reg;

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_chan
            tocu_action_e act;
            logic force_hit;

            // Low write joins the temp byte into one 16-bit load
            tocu_cmp_reg #(
                .WIDTH(WIDTH)
            ) u_cmp (
                .core_clk(core_clk),
                .srst(srst),
                .buffered(pwm_mode),
                .wr_full(compare_value_low_wr[ch]),
                .wr_data(WIDTH'({temp_reg, cpu_wdata})),
                .xfer(xfer_point),
                .active_value(compare_top_w[ch]),
                .cpu_view(compare_value[ch])
            );

            // Full-width compare, every cycle
            assign equal_w[ch] = (counter_value == compare_top_w[ch]);
            // Counts on a tick only, and not right after a counter write
            assign match_evt[ch] = timer_tick && equal_w[ch] && !blocked;
            assign compare_match[ch] = match_evt[ch];

            // Forcing only exists outside PWM modes
            assign force_hit = force_compare_strobe[ch] && !pwm_mode;

            // Unbuffered field read live; match beats bottom and force
            always_comb
            begin
                act = TOCU_ACT_NONE;
                if (match_evt[ch])
                    act = match_action(pwm_mode, fast_mode, count_down, output_mode_field[ch]);
                else if (fast_mode && timer_tick && counter_at_bottom)
                    act = bottom_action(output_mode_field[ch]);
                else if (force_hit)
                    act = match_action(1'b0, 1'b0, 1'b0, output_mode_field[ch]);
            end

            tocu_wave_out u_wave (
                .core_clk(core_clk),
                .srst(srst),
                .act(act),
                .output_mode_field(output_mode_field[ch]),
                .port_out_value(port_out_value[ch]),
                .pin_direction_bit(pin_direction_bit[ch]),
                .wave_output(wave_output[ch]),
                .pin_out(pin_out[ch]),
                .pin_oe(pin_oe[ch])
            );

            // Flag: a match sets it, ack or written one clears; set wins
            always_ff @(posedge core_clk)
            begin
                if (srst)
                    flag_reg[ch] <= `TOCU_FLAG_RST;
                else if (match_evt[ch])
                    flag_reg[ch] <= 1'b1;
                else if (irq_ack[ch] || flag_clear_wr[ch])
                    flag_reg[ch] <= 1'b0;
            end

            assign compare_flag[ch] = flag_reg[ch];
            assign compare_irq[ch] = flag_reg[ch] && compare_irq_enable[ch];

            // ----------------------------------------
            // Checks
            // ----------------------------------------

            property p_flag_after_match;
                @(posedge core_clk) disable iff (srst)
                (timer_tick && equal_w[ch] && !block_reg && !counter_write) |=> compare_flag[ch];
            endproperty
            a_flag_after_match: assert property (p_flag_after_match)
                else $error("match did not set compare flag");

            property p_irq_request;
                @(posedge core_clk) disable iff (srst)
                (compare_flag[ch] && compare_irq_enable[ch]) |-> compare_irq[ch];
            endproperty
            a_irq_request: assert property (p_irq_request)
                else $error("enabled flag raised no interrupt");

            property p_flag_clear;
                @(posedge core_clk) disable iff (srst)
                ((irq_ack[ch] || flag_clear_wr[ch]) && !match_evt[ch]) |=> !compare_flag[ch];
            endproperty
            a_flag_clear: assert property (p_flag_clear)
                else $error("compare flag not cleared");

            property p_block_after_write;
                @(posedge core_clk) disable iff (srst)
                counter_write ##1 (!counter_write && timer_tick) |-> !compare_match[ch];
            endproperty
            a_block_after_write: assert property (p_block_after_write)
                else $error("match passed in blocked tick");

            property p_force_no_flag;
                @(posedge core_clk) disable iff (srst)
                (force_hit && !timer_tick && !compare_flag[ch]) |=> !compare_flag[ch];
            endproperty
            a_force_no_flag: assert property (p_force_no_flag)
                else $error("forced compare set the flag");

            property p_force_toggle;
                @(posedge core_clk) disable iff (srst)
                (force_hit && !timer_tick && output_mode_field[ch] == `TOCU_COM_TOGGLE)
                    |=> (wave_output[ch] != $past(wave_output[ch]));
            endproperty
            a_force_toggle: assert property (p_force_toggle)
                else $error("forced toggle left output unchanged");

            property p_field_off_holds;
                @(posedge core_clk) disable iff (srst)
                (output_mode_field[ch] == `TOCU_COM_OFF) |=> (wave_output[ch] == $past(wave_output[ch]));
            endproperty
            a_field_off_holds: assert property (p_field_off_holds)
                else $error("output changed with mode field zero");

            property p_fast_bottom;
                @(posedge core_clk) disable iff (srst)
                (fast_mode && timer_tick && counter_at_bottom && !match_evt[ch]
                    && output_mode_field[ch] == `TOCU_COM_CLEAR) |=> wave_output[ch];
            endproperty
            a_fast_bottom: assert property (p_fast_bottom)
                else $error("non-inverting output not set at bottom");

            property p_irq_masked;
                @(posedge core_clk) disable iff (srst)
                !compare_irq_enable[ch] |-> !compare_irq[ch];
            endproperty
            a_irq_masked: assert property (p_irq_masked)
                else $error("masked channel raised an interrupt");

            property p_match_toggle;
                @(posedge core_clk) disable iff (srst)
                (!pwm_mode && match_evt[ch] && output_mode_field[ch] == `TOCU_COM_TOGGLE)
                    |=> (wave_output[ch] != $past(wave_output[ch]));
            endproperty
            a_match_toggle: assert property (p_match_toggle)
                else $error("toggle match left output unchanged");

            property p_pwm_ignores_force;
                @(posedge core_clk) disable iff (srst)
                (pwm_mode && !timer_tick) |=> $stable(wave_output[ch]);
            endproperty
            a_pwm_ignores_force: assert property (p_pwm_ignores_force)
                else $error("output moved in PWM mode without a tick");
        end
    endgenerate

endmodule : tocu_output_compare

// file: verification/tocu_cpu_model.sv
// CPU side model that writes compare words over the 8-bit bus
module tocu_cpu_model
(
    input wire logic core_clk,
    input wire logic req,
    input wire logic req_ch,
    input wire logic [15:0] req_value,
    output logic [7:0] cpu_wdata,
    output logic [1:0] compare_value_high_wr,
    output logic [1:0] compare_value_low_wr,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ch;
    logic [15:0] val;

    // Idle bus at time zero
    initial
    begin
        cpu_wdata = 8'h5a;
        compare_value_high_wr = 2'h0;
        compare_value_low_wr = 2'h0;
        busy = 1'h0;
    end

    // High byte strictly first; released bus shows inverted data, not stale data
    always
    begin
        @(posedge core_clk);
        if (req)
        begin
            ch = req_ch;
            val = req_value;
            @(negedge core_clk);
            busy = 1'h1;
            compare_value_high_wr[ch] = 1'h1;
            cpu_wdata = val[15:8];
            @(negedge core_clk);
            compare_value_high_wr = 2'h0;
            compare_value_low_wr[ch] = 1'h1;
            cpu_wdata = val[7:0];
            @(negedge core_clk);
            compare_value_low_wr = 2'h0;
            cpu_wdata = ~val[7:0];
            busy = 1'h0;
        end
    end
endmodule : tocu_cpu_model

// file: verification/tocu_output_compare_test.sv
// Self-checking testbench of the two-channel output compare block
`include "tocu_map.svh"
module tocu_output_compare_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, srst, timer_tick, counter_at_top, counter_at_bottom, pwm_mode, counter_write;
    logic temp_load, req, req_ch, busy, top_from_compare_a, count_down;
    logic [15:0] counter_value, req_value, v, compare_top_a;
    logic [3:0] waveform_mode;
    logic [7:0] cpu_wdata, temp_load_data, temp_byte;
    logic [1:0] hwr, lwr, flag_clear_wr, irq_ack, compare_irq_enable, force_compare_strobe;
    logic [1:0] port_out_value, pin_direction_bit, match_seen, wexp;
    logic [1:0] compare_match, compare_flag, compare_irq, wave_output, pin_out, pin_oe;
    logic [1:0][1:0] output_mode_field;
    logic [1:0][15:0] compare_value, cmp;
    logic [3:0] modes [5];
    int seed, mismatches, total_checks, cycles, i, f;
    localparam logic [3:0] DUAL_MODE = 4'h1; // Any PWM code outside the fast set

    tocu_output_compare #(.NCH(2), .WIDTH(16)) dut_u (.core_clk(core_clk), .srst(srst),
        .timer_tick(timer_tick), .counter_value(counter_value), .counter_at_top(counter_at_top),
        .counter_at_bottom(counter_at_bottom), .count_down(count_down), .pwm_mode(pwm_mode),
        .waveform_mode(waveform_mode), .counter_write(counter_write), .cpu_wdata(cpu_wdata),
        .compare_value_high_wr(hwr), .compare_value_low_wr(lwr), .temp_load(temp_load),
        .temp_load_data(temp_load_data), .flag_clear_wr(flag_clear_wr), .irq_ack(irq_ack),
        .compare_irq_enable(compare_irq_enable), .force_compare_strobe(force_compare_strobe),
        .output_mode_field(output_mode_field), .port_out_value(port_out_value),
        .pin_direction_bit(pin_direction_bit), .temp_byte(temp_byte), .compare_value(compare_value),
        .compare_top_a(compare_top_a), .top_from_compare_a(top_from_compare_a),
        .compare_match(compare_match), .compare_flag(compare_flag), .compare_irq(compare_irq),
        .wave_output(wave_output), .pin_out(pin_out), .pin_oe(pin_oe));

    tocu_cpu_model cpu_u (.core_clk(core_clk), .req(req), .req_ch(req_ch), .req_value(req_value),
        .cpu_wdata(cpu_wdata), .compare_value_high_wr(hwr), .compare_value_low_wr(lwr), .busy(busy));

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    always #2 core_clk = ~core_clk;

    // Hang guard, far above the fewer than a hundred cycles the run needs
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            summarize();
        end
    end

    task summarize();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task step();
        @(negedge core_clk);
    endtask : step

    // One timer tick; combinational match is captured before the edge lands
    task tick(input logic top, input logic bot);
        timer_tick = 1'h1;
        counter_at_top = top;
        counter_at_bottom = bot;
        #1;
        match_seen = compare_match;
        step();
        timer_tick = 1'h0;
        counter_at_top = 1'h0;
        counter_at_bottom = 1'h0;
    endtask : tick

    task cpu_write(input logic ch, input logic [15:0] val);
        req = 1'h1;
        req_ch = ch;
        req_value = val;
        step();
        req = 1'h0;
        for (int n = 0; n < 10; n++)
        begin
            @(posedge core_clk);
            if (!busy)
                break;
        end
        step();
    endtask : cpu_write

    // Expected wave register after a non-PWM action
    function automatic logic act_exp(input logic [1:0] fld, input logic w);
        case (fld)
            2'h0: act_exp = w;
            2'h1: act_exp = ~w;
            2'h2: act_exp = 1'h0;
            default: act_exp = 1'h1;
        endcase
    endfunction : act_exp

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {core_clk, timer_tick, counter_at_top, counter_at_bottom, pwm_mode, counter_write, count_down} = 7'h00;
        {temp_load, req, req_ch, flag_clear_wr, irq_ack, compare_irq_enable} = 9'h000;
        {force_compare_strobe, port_out_value, pin_direction_bit, output_mode_field} = 10'h000;
        counter_value = 16'h0000;
        req_value = 16'h0000;
        temp_load_data = 8'h00;
        waveform_mode = `TOCU_WGM_NORMAL;
        seed = 1;
        wexp = 2'h0;
        srst = 1'h1;
        repeat (12) @(posedge core_clk);
        step();
        srst = 1'h0;
        check(wave_output, 32'h0000_0000);
        check(compare_flag, 32'h0000_0000);
        check(compare_value, 32'h0000_0000);
        // Direct writes while unbuffered; temp byte holds the high byte
        for (i = 0; i < 4; i++)
        begin
            v = $random(seed);
            cpu_write(i[0], v);
            cmp[i[0]] = v;
            check(compare_value[i[0]], v);
            check(temp_byte, v[15:8]);
        end
        check(compare_top_a, cmp[0]);
        temp_load_data = $random(seed);
        temp_load = 1'h1;
        step();
        temp_load = 1'h0;
        check(temp_byte, temp_load_data);
        // Matches, flags and interrupts; only channel A interrupt enabled
        waveform_mode = `TOCU_WGM_CTC_CMPA;
        compare_irq_enable = 2'h1;
        for (i = 0; i < 2; i++)
        begin
            output_mode_field = 4'h0;
            output_mode_field[i] = `TOCU_COM_TOGGLE;
            counter_value = cmp[i] ^ (16'h0001 << ($unsigned($random(seed)) % 16));
            tick(1'h0, 1'h0);
            check(match_seen[i], 1'h0);
            counter_value = cmp[i];
            tick(1'h0, 1'h0);
            wexp[i] = ~wexp[i];
            check(match_seen[i], 1'h1);
            check(compare_flag[i], 1'h1);
            check(compare_irq[i], i == 0);
            check(wave_output[i], wexp[i]);
            flag_clear_wr = (i == 0) ? 2'h1 : 2'h0;
            irq_ack = (i == 0) ? 2'h0 : 2'h2;
            step();
            flag_clear_wr = 2'h0;
            irq_ack = 2'h0;
            check(compare_flag[i], 1'h0);
        end
        // A counter write blocks exactly the next tick's match
        output_mode_field = 4'h0;
        counter_write = 1'h1;
        step();
        counter_write = 1'h0;
        counter_value = cmp[0];
        tick(1'h0, 1'h0);
        check(match_seen[0], 1'h0);
        check(compare_flag[0], 1'h0);
        tick(1'h0, 1'h0);
        check(match_seen[0], 1'h1);
        flag_clear_wr = 2'h1;
        step();
        flag_clear_wr = 2'h0;
        // Forced actions for every field value, no flag
        waveform_mode = `TOCU_WGM_NORMAL;
        for (f = 0; f < 4; f++)
            for (i = 0; i < 2; i++)
            begin
                output_mode_field[i] = f[1:0];
                force_compare_strobe = 2'h1 << i;
                step();
                force_compare_strobe = 2'h0;
                wexp[i] = act_exp(f[1:0], wexp[i]);
                check(wave_output[i], wexp[i]);
                check(compare_flag[i], 1'h0);
            end
        // Force ignored in PWM; register kept across the mode change
        pwm_mode = 1'h1;
        waveform_mode = `TOCU_WGM_FAST_CMPA;
        output_mode_field[0] = `TOCU_COM_CLEAR;
        force_compare_strobe = 2'h1;
        step();
        force_compare_strobe = 2'h0;
        step();
        check(wave_output, wexp);
        // Pin override; port value, direction and output mode field all change in the same step
        for (i = 0; i < 8; i++)
        begin
            v = $random(seed);
            port_out_value = v[1:0];
            pin_direction_bit = v[3:2];
            output_mode_field = v[7:4];
            #1;
            for (f = 0; f < 2; f++)
            begin
                check(pin_out[f], (output_mode_field[f] != 2'h0) ? wexp[f] : port_out_value[f]);
                check(pin_oe[f], pin_direction_bit[f]);
            end
            step();
        end
        // Top source decode over a table of modes
        modes = '{`TOCU_WGM_NORMAL, `TOCU_WGM_CTC_CMPA, `TOCU_WGM_CTC_CAPT, `TOCU_WGM_FAST_8, `TOCU_WGM_FAST_CMPA};
        foreach (modes[k])
        begin
            waveform_mode = modes[k];
            #1;
            check(top_from_compare_a, modes[k] == 4'h4 || modes[k] == 4'hf);
            step();
        end
        // Buffered write moves to the active register only at bottom
        output_mode_field = 4'h0;
        v = $random(seed);
        v[0] = 1'h1;
        cpu_write(1'h0, v);
        check(compare_value[0], v);
        check(compare_top_a, cmp[0]);
        counter_value = 16'h0000;
        tick(1'h1, 1'h0);
        check(compare_top_a, cmp[0]);
        tick(1'h0, 1'h1);
        check(compare_top_a, v);
        cmp[0] = v;
        // Single-slope PWM, both polarities, field changed just before use
        for (f = 2; f < 4; f++)
        begin
            output_mode_field[0] = f[1:0];
            counter_value = 16'h0000;
            tick(1'h0, 1'h1);
            check(wave_output[0], f == 2);
            counter_value = cmp[0];
            tick(1'h0, 1'h0);
            check(wave_output[0], f == 3);
        end
        // Dual slope: reload at top only, match action flips counting down
        waveform_mode = DUAL_MODE;
        output_mode_field[1] = `TOCU_COM_SET;
        cpu_write(1'h1, ~cmp[1]);
        counter_value = ~cmp[1];
        tick(1'h0, 1'h1);
        tick(1'h0, 1'h0);
        check(match_seen[1], 1'h0);
        tick(1'h1, 1'h0);
        count_down = 1'h1;
        tick(1'h0, 1'h0);
        check({match_seen[1], wave_output[1]}, 2'h2);
        count_down = 1'h0;
        tick(1'h0, 1'h0);
        check(wave_output[1], 1'h1);
        summarize();
    end
endmodule : tocu_output_compare_test
